// ==== rtl/csb_timer.sv ====
// Frame timer: composite sync and blank with serration, and with equalization when interlaced
`timescale 1ns/1ps
`default_nettype none

module csb_timer
  import csb_pkg::*;
#(
  parameter int LINE_W  = csb_pkg::LINE_W_DEF,
  parameter int FRAME_W = csb_pkg::FRAME_W_DEF
) (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               reset_n_in,
  // Control
  input  wire logic               interlace_disable_in,
  input  wire logic [1:0]         output_combination_select_in,
  // Horizontal timing values
  input  wire logic [LINE_W-1:0]  line_total_in,
  input  wire logic [LINE_W-1:0]  line_sync_end_in,
  input  wire logic [LINE_W-1:0]  serration_end_in,
  input  wire logic [LINE_W-1:0]  line_blank_end_in,
  input  wire logic [LINE_W-1:0]  line_blank_start_in,
  input  wire logic [LINE_W-1:0]  area_start_in,
  input  wire logic [LINE_W-1:0]  area_end_in,
  // Vertical timing values
  input  wire logic [FRAME_W-1:0] frame_total_in,
  input  wire logic [FRAME_W-1:0] frame_sync_end_in,
  input  wire logic [FRAME_W-1:0] frame_blank_start_in,
  input  wire logic [FRAME_W-1:0] frame_blank_end_in,
  // Status
  output var  logic [LINE_W-1:0]  pixel_counter_out,
  output var  logic [FRAME_W-1:0] line_counter_out,
  // Video pins
  output var  logic               hsync_out,
  output var  logic               vsync_out,
  output var  logic               sync_or_line_blank_out,
  output var  logic               blank_or_frame_blank_out,
  output var  logic               area_window_out
);

  import csb_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [LINE_W-1:0]    pixel_counter;
  logic [FRAME_W-1:0]   line_counter;
  csb_region_e          region;
  csb_region_e          next_region;
  logic                 hsync;
  logic                 composite_sync;
  logic                 line_blank;
  logic                 frame_blank;
  logic                 area_window;
  logic                 next_hsync;
  logic                 next_composite_sync;
  logic                 interlaced;
  logic                 line_end;
  logic                 line_mid;
  logic                 vstep;
  logic                 serr_next;
  logic                 eq_next;
  logic                 quiet_next;
  logic                 vsync;
  logic                 composite_blank;
  logic [LINE_W-1:0]    half_total;
  logic [LINE_W-1:0]    half_sync;
  logic [LINE_W-1:0]    eq_mid_stop;
  logic [LINE_W-1:0]    serr_mid_stop;
  logic [LINE_W:0]      total_plus_sync;
  logic [FRAME_W-1:0]   vsync_stop;
  logic [PIN_COUNT-1:0] pin_select;
  logic [PIN_COUNT-1:0] pin_delayed;

  // ==========================================================
  // Mode and derived points
  // ==========================================================
  // Interlace disable high means one field per frame
  assign interlaced = !interlace_disable_in;

  // Halving truncates; odd totals give an exact midpoint
  assign half_total  = line_total_in >> HALF_SHIFT;
  assign half_sync   = line_sync_end_in >> HALF_SHIFT;
  assign total_plus_sync = {1'b0, line_total_in}
                         + {1'b0, line_sync_end_in};
  assign eq_mid_stop = total_plus_sync[LINE_W:HALF_SHIFT];
  assign serr_mid_stop =
    LINE_W'(half_total + serration_end_in);
  assign vsync_stop  =
    FRAME_W'(frame_sync_end_in - FRAME_W'(1)) >> HALF_SHIFT;

  assign line_end = (pixel_counter == line_total_in);
  assign line_mid = (pixel_counter == half_total);

  // Vertical steps on halflines when interlaced, lines otherwise
  assign vstep = line_end || (interlaced && line_mid);

  // ==========================================================
  // Pixel counter
  // ==========================================================
  // Line is line_total + 1 clocks long
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pixel_counter <= '0;
    end else if (line_end) begin
      pixel_counter <= '0;
    end else begin
      pixel_counter <= pixel_counter + LINE_W'(1);
    end
  end

  // ==========================================================
  // Line counter
  // ==========================================================
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_counter <= '0;
    end else if (vstep) begin
      if (line_counter == frame_total_in) begin
        line_counter <= '0;
      end else begin
        line_counter <= line_counter + FRAME_W'(1);
      end
    end
  end

  // ==========================================================
  // Vertical region sequencer
  // ==========================================================
  // Regions only move at (half)line ends, so they stay whole
  always_comb begin
    next_region = region;
    if (vstep) begin
      case (region)
        CSB_ACTIVE: begin
          if (line_counter == frame_total_in) begin
            next_region = CSB_SERRATION;
          end else if (line_counter == frame_blank_start_in) begin
            next_region = CSB_PRE_EQ;
          end
        end
        CSB_PRE_EQ: begin
          if (line_counter == frame_total_in) begin
            next_region = CSB_SERRATION;
          end
        end
        CSB_SERRATION: begin
          if (line_counter == vsync_stop) begin
            next_region = CSB_POST_EQ;
          end
        end
        CSB_POST_EQ: begin
          // Counts 0..s sync, s+1..2s+1 post; 2s+1 is sync end
          if (line_counter == frame_total_in) begin
            next_region = CSB_SERRATION;
          end else if (line_counter == frame_sync_end_in) begin
            next_region = CSB_ACTIVE;
          end
        end
        default: begin
          next_region = CSB_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      region <= CSB_ACTIVE;
    end else begin
      region <= next_region;
    end
  end

  // Vertical sync is low exactly across the serration region
  assign vsync = (region == CSB_SERRATION) ? LVL_ACTIVE
                                          : LVL_INACTIVE;

  // ==========================================================
  // Frame blank
  // ==========================================================
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_blank <= LVL_ACTIVE;
    end else if (vstep) begin
      if (line_counter == frame_blank_start_in) begin
        frame_blank <= LVL_ACTIVE;
      end else if (line_counter == frame_blank_end_in) begin
        frame_blank <= LVL_INACTIVE;
      end
    end
  end

  // ==========================================================
  // Line sync
  // ==========================================================
  // Start wins if both values coincide; no ordering is assumed
  always_comb begin
    next_hsync = hsync;
    if (line_end) begin
      next_hsync = LVL_ACTIVE;
    end else if (pixel_counter == line_sync_end_in) begin
      next_hsync = LVL_INACTIVE;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hsync <= LVL_INACTIVE;
    end else begin
      hsync <= next_hsync;
    end
  end

  // ==========================================================
  // Composite sync
  // ==========================================================
  // Region of the cycle that follows, so the first pulse of a
  // region starts on the same edge the region does
  assign serr_next  = (next_region == CSB_SERRATION);
  assign eq_next    = interlaced && ((next_region == CSB_PRE_EQ)
                   || (next_region == CSB_POST_EQ));
  assign quiet_next = !serr_next && !eq_next;

  always_comb begin
    next_composite_sync = composite_sync;
    if (serr_next) begin
      if (line_end || (interlaced && line_mid)) begin
        next_composite_sync = LVL_ACTIVE;
      end else if (pixel_counter == serration_end_in) begin
        next_composite_sync = LVL_INACTIVE;
      end else if (interlaced && pixel_counter == serr_mid_stop) begin
        next_composite_sync = LVL_INACTIVE;
      end
    end else if (eq_next) begin
      if (line_end || line_mid) begin
        next_composite_sync = LVL_ACTIVE;
      end else if (pixel_counter == half_sync
                   || pixel_counter == eq_mid_stop) begin
        next_composite_sync = LVL_INACTIVE;
      end
    end else begin
      next_composite_sync = next_hsync;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      composite_sync <= LVL_INACTIVE;
    end else begin
      composite_sync <= next_composite_sync;
    end
  end

  // ==========================================================
  // Line blank and area
  // ==========================================================
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_blank <= LVL_ACTIVE;
    end else if (pixel_counter == line_blank_start_in) begin
      line_blank <= LVL_ACTIVE;
    end else if (pixel_counter == line_blank_end_in) begin
      line_blank <= LVL_INACTIVE;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      area_window <= AREA_OFF;
    end else if (pixel_counter == area_end_in) begin
      area_window <= AREA_OFF;
    end else if (pixel_counter == area_start_in) begin
      area_window <= AREA_ON;
    end
  end

  // Active-low OR of the two blanks
  assign composite_blank = line_blank & frame_blank;

  // ==========================================================
  // Pin combination and 2.5 clock delay
  // ==========================================================
  // Codes other than composite fall back to separate pins
  always_comb begin
    if (output_combination_select_in == SEL_COMPOSITE) begin
      pin_select = {hsync, vsync, composite_sync, composite_blank,
                    area_window};
    end else begin
      pin_select = {hsync, vsync, line_blank, frame_blank,
                    area_window};
    end
  end

  // Equal lag on every pin keeps relative timing exact
  csb_pin_delay #(
    .WIDTH     (PIN_COUNT),
    .RESET_VAL (PIN_RESET)
  ) u_pin_delay (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .data_in    (pin_select),
    .data_out   (pin_delayed)
  );

  assign hsync_out                = pin_delayed[4];
  assign vsync_out                = pin_delayed[3];
  assign sync_or_line_blank_out   = pin_delayed[2];
  assign blank_or_frame_blank_out = pin_delayed[1];
  assign area_window_out          = pin_delayed[0];
  assign pixel_counter_out        = pixel_counter;
  assign line_counter_out         = line_counter;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence line_wrap_s;
    line_end ##1 (pixel_counter == '0);
  endsequence

  sequence sync_start_s;
    line_end ##1 (hsync == LVL_ACTIVE);
  endsequence

  pix_wrap_a: assert property (
    line_end |-> line_wrap_s)
    else $error("pixel counter did not wrap at line total");

  pix_step_a: assert property (
    !line_end |=> pixel_counter == $past(pixel_counter) + 1'b1)
    else $error("pixel counter did not step by one");

  sync_fall_a: assert property (
    line_end |-> sync_start_s)
    else $error("line sync did not start at line total");

  sync_rise_a: assert property (
    (pixel_counter == line_sync_end_in) && !line_end
    |=> hsync == LVL_INACTIVE)
    else $error("line sync did not end at sync end");

  blank_start_a: assert property (
    pixel_counter == line_blank_start_in
    |=> line_blank == LVL_ACTIVE)
    else $error("line blank did not start");

  area_on_a: assert property (
    (pixel_counter == area_start_in)
    && (pixel_counter != area_end_in)
    |=> area_window == AREA_ON)
    else $error("area window did not open");

  composite_sync_follow_a: assert property (
    quiet_next |=> composite_sync == hsync)
    else $error("composite sync differs from line sync");

  serr_end_a: assert property (
    serr_next && interlace_disable_in && !line_end
    && (pixel_counter == serration_end_in)
    |=> composite_sync == LVL_INACTIVE)
    else $error("serration pulse did not end");

  eq_mid_a: assert property (
    eq_next && line_mid |=> composite_sync == LVL_ACTIVE)
    else $error("equalization pulse missing at midline");

  serr_begin_a: assert property (
    vstep && (line_counter == frame_total_in)
    |=> region == CSB_SERRATION ##0 vsync == LVL_ACTIVE)
    else $error("serration region did not start");

  region_whole_a: assert property (
    region != $past(region) |-> $past(vstep))
    else $error("region changed inside a halfline");

  // Rising stage plus falling stage: a pin sampled at one edge
  // shows the internal state sampled at the edge before
  pin_lag_a: assert property (
    ##2 (hsync_out == $past(hsync)
         && area_window_out == $past(area_window)))
    else $error("pin lag is not 2.5 clocks");

  cblank_pin_a: assert property (
    (output_combination_select_in == SEL_COMPOSITE)
    [*3] |-> blank_or_frame_blank_out
    == ($past(line_blank) & $past(frame_blank)))
    else $error("composite blank pin wrong");

endmodule : csb_timer

`default_nettype wire

// ==== rtl/csb_pkg.sv ====
// Shared constants and types for the composite sync and blank timer
package csb_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int LINE_W_DEF  = 16;
  localparam int FRAME_W_DEF = 16;
  localparam int PIN_COUNT   = 5;

  // ==========================================================
  // Output combination codes
  // ==========================================================
  localparam logic [1:0] SEL_COMPOSITE = 2'h2;
  localparam logic [1:0] SEL_SEPARATE  = 2'h3;

  // ==========================================================
  // Levels and reset values
  // ==========================================================
  localparam logic LVL_ACTIVE   = 1'b0;
  localparam logic LVL_INACTIVE = 1'b1;
  localparam logic AREA_ON      = 1'b1;
  localparam logic AREA_OFF     = 1'b0;
  localparam logic [4:0] PIN_RESET = 5'h1C;
  localparam int   HALF_SHIFT   = 1;

  // ==========================================================
  // Pin delay: 2.5 frame clock periods
  // ==========================================================
  localparam real  CLK_PERIOD_NS = 8.0;
  localparam real  PIN_DELAY_NS  = 20.0;
  localparam int   PIN_DELAY_HALF =
    int'(PIN_DELAY_NS * 2.0 / CLK_PERIOD_NS);

  // ==========================================================
  // Vertical blanking regions
  // ==========================================================
  typedef enum logic [1:0] {
    CSB_ACTIVE,
    CSB_PRE_EQ,
    CSB_SERRATION,
    CSB_POST_EQ
  } csb_region_e;

endpackage : csb_pkg

// ==== rtl/csb_pin_delay.sv ====
// Pin delay stage: one rising edge stage then one falling edge stage
`timescale 1ns/1ps
`default_nettype none

module csb_pin_delay #(
  parameter int              WIDTH     = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  // Data
  input  wire logic [WIDTH-1:0] data_in,
  output var  logic [WIDTH-1:0] data_out
);

  logic [WIDTH-1:0] rise_stage;

  // ==========================================================
  // Full-cycle stage
  // ==========================================================
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_stage <= RESET_VAL;
    end else begin
      rise_stage <= data_in;
    end
  end

  // Falling edge adds the half period the pins need
  always_ff @(negedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_out <= RESET_VAL;
    end else begin
      data_out <= rise_stage;
    end
  end

endmodule : csb_pin_delay

`default_nettype wire

// ==== sim/csb_monitor.sv ====
// Display-side receiver that measures line sync period and width
`timescale 1ns/1ps
`default_nettype none

module csb_monitor (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // Video pins from the timer
  input  wire logic        hsync_in,
  // Measured figures, in frame clocks
  output var  logic [15:0] line_period_out,
  output var  logic [15:0] sync_width_out
);
  // ==========================================================
  // Edge timing
  // ==========================================================
  logic [15:0] run;
  logic        last_hs;

  // Restart the count at each falling sync edge, as a monitor
  // locks its line oscillator; the first report after reset is the count since reset
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run             <= 16'h0000;
      last_hs         <= 1'b1;
      line_period_out <= 16'h0000;
      sync_width_out  <= 16'h0000;
    end else begin
      last_hs <= hsync_in;
      if (last_hs && !hsync_in) begin
        line_period_out <= run;
        run             <= 16'h0001;
      end else begin
        run <= run + 16'h0001;
      end
      if (!last_hs && hsync_in) begin
        sync_width_out <= run;
      end
    end
  end
endmodule : csb_monitor
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the composite sync and blank timer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import csb_pkg::*;

  // ==========================================================
  // Stimulus, observed pins and reference state
  // ==========================================================
  logic        clock_in, reset_n_in, il_dis;
  logic [1:0]  sel;
  logic [15:0] lt, lse, se, lbe, lbs, ars, are, ft, fse, fbs, fbe;
  logic [15:0] pix_o, lc_o, per_o, wid_o;
  logic        hs_o, vs_o, slb_o, bfb_o, area_o;
  logic [15:0] r_pix, r_lc;
  logic        r_hs, r_vs, r_lb, r_fb, r_ar, r_cs;
  logic        e_hs, e_vs, e_slb, e_bfb, e_ar;
  csb_region_e r_reg;
  int          bad_count = 0;
  int          checked   = 0;
  int          cycles    = 0;

  csb_timer dut (
    .clock_in(clock_in), .reset_n_in(reset_n_in),
    .interlace_disable_in(il_dis), .output_combination_select_in(sel),
    .line_total_in(lt), .line_sync_end_in(lse), .serration_end_in(se),
    .line_blank_end_in(lbe), .line_blank_start_in(lbs),
    .area_start_in(ars), .area_end_in(are), .frame_total_in(ft),
    .frame_sync_end_in(fse), .frame_blank_start_in(fbs),
    .frame_blank_end_in(fbe), .pixel_counter_out(pix_o),
    .line_counter_out(lc_o), .hsync_out(hs_o), .vsync_out(vs_o),
    .sync_or_line_blank_out(slb_o), .blank_or_frame_blank_out(bfb_o),
    .area_window_out(area_o));

  csb_monitor mon (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .hsync_in(hs_o),
    .line_period_out(per_o), .sync_width_out(wid_o));

  // 125 MHz frame clock
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Hang guard: a full run needs under 4000 cycles
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ==========================================================
  // Compare and closing tasks
  // ==========================================================
  task automatic cmp_bit(input string what, input logic exp,
                         input logic seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask : cmp_bit

  task automatic cmp_num(input string what, input logic [15:0] exp,
                         input logic [15:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp_num

  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Reference timer, one call per rising edge
  // ==========================================================
  task automatic model_edge();
    logic [15:0] p;
    logic [15:0] half;
    logic        il;
    p    = r_pix;
    half = lt >> 1;
    il   = !il_dis;
    // Pins show the state held before this edge: 2.5 period lag
    e_hs  = r_hs;
    e_vs  = r_vs;
    e_ar  = r_ar;
    e_slb = (sel == SEL_COMPOSITE) ? r_cs : r_lb;
    e_bfb = (sel == SEL_COMPOSITE) ? (r_lb & r_fb) : r_fb;
    if (p == lt || (il && p == half)) begin
      if (r_lc == ft) r_reg = CSB_SERRATION;
      else if (r_reg == CSB_SERRATION && r_lc == ((fse - 1) >> 1))
        r_reg = CSB_POST_EQ;
      else if (r_reg == CSB_POST_EQ && r_lc == fse) r_reg = CSB_ACTIVE;
      else if (r_reg == CSB_ACTIVE && r_lc == fbs) r_reg = CSB_PRE_EQ;
      if (r_lc == fbs) r_fb = 1'b0;
      else if (r_lc == fbe) r_fb = 1'b1;
      r_lc = (r_lc == ft) ? 16'h0000 : r_lc + 16'h0001;
    end
    r_vs = (r_reg != CSB_SERRATION);
    if (p == lt) r_hs = 1'b0;
    else if (p == lse) r_hs = 1'b1;
    if (p == lbs) r_lb = 1'b0;
    else if (p == lbe) r_lb = 1'b1;
    if (p == are) r_ar = 1'b0;
    else if (p == ars) r_ar = 1'b1;
    if (r_reg == CSB_SERRATION) begin
      if (p == lt || (il && p == half)) r_cs = 1'b0;
      else if (p == se || (il && p == half + se)) r_cs = 1'b1;
    end else if (r_reg != CSB_ACTIVE && il) begin
      if (p == lt || p == half) r_cs = 1'b0;
      else if (p == (lse >> 1) || p == ((lt + lse) >> 1)) r_cs = 1'b1;
    end else begin
      r_cs = r_hs;
    end
    r_pix = (p == lt) ? 16'h0000 : p + 16'h0001;
  endtask : model_edge

  // ==========================================================
  // One configuration: reset, run several frames, compare
  // ==========================================================
  task automatic run_test(input string name, input logic i,
                          input logic [1:0] s, input logic [15:0] be,
                          input logic [15:0] bs, input logic [15:0] as,
                          input logic [15:0] ae);
    int n;
    @(negedge clock_in);
    reset_n_in = 1'b0;
    il_dis = i;
    sel = s;
    lbe = be;
    lbs = bs;
    ars = as;
    are = ae;
    {r_pix, r_lc} = 32'h0000_0000;
    {r_hs, r_vs, r_lb, r_fb, r_ar, r_cs} = 6'h31;
    r_reg = CSB_ACTIVE;
    repeat (10) @(negedge clock_in);
    reset_n_in = 1'b1;
    for (n = 0; n < 720; n++) begin
      @(posedge clock_in);
      model_edge();
      #6;
      cmp_num("pixel counter", r_pix, pix_o);
      cmp_num("line counter", r_lc, lc_o);
      if (n > 1) begin
        cmp_bit("line sync", e_hs, hs_o);
        cmp_bit("frame sync", e_vs, vs_o);
        cmp_bit("sync or blank", e_slb, slb_o);
        cmp_bit("blank", e_bfb, bfb_o);
        cmp_bit("area window", e_ar, area_o);
      end
    end
    cmp_num("line period", lt + 16'h0001, per_o);
    cmp_num("sync width", lse + 16'h0001, wid_o);
    $display("test %s done, mismatches so far %0d", name, bad_count);
  endtask : run_test

  // Main sequence: static timing, then each mode and output set
  initial begin
    reset_n_in = 1'b0;
    il_dis = 1'b1;
    sel = SEL_COMPOSITE;
    lt = 16'h0013;
    lse = 16'h0003;
    se = 16'h0005;
    {lbe, lbs, ars, are} = {16'h0005, 16'h0010, 16'h0007, 16'h000E};
    {ft, fse, fbs, fbe} = {16'h000B, 16'h0005, 16'h0009, 16'h0004};
    run_test("nonint composite", 1'b1, SEL_COMPOSITE, 16'h0005, 16'h0010,
             16'h0007, 16'h000E);
    run_test("nonint separate", 1'b1, SEL_SEPARATE, 16'h0005, 16'h0010,
             16'h0007, 16'h000E);
    run_test("interlaced composite", 1'b0, SEL_COMPOSITE, 16'h0005,
             16'h0010, 16'h0007, 16'h000E);
    run_test("interlaced separate", 1'b0, SEL_SEPARATE, 16'h0005,
             16'h0010, 16'h0007, 16'h000E);
    run_test("any order", 1'b1, SEL_SEPARATE, 16'h0011, 16'h0001,
             16'h000F, 16'h0004);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
